// >>> dv/dcw_drive_model.sv
`timescale 1ns/1ps
module dcw_drive_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Drive bus
    input  wire logic        drv_cmd_data,
    input  wire logic        drv_cmd_frame,
    output logic             drv_status_valid,
    output logic [15:0]      drv_status_word,
    output logic             drv_error,
    // Bench control
    input  wire logic        err_set,
    input  wire logic [15:0] status_in,
    input  wire logic [2:0]  delay,
    output logic [15:0]      last_cmd,
    output logic [7:0]       n_cmds
);
    logic [7:0]  k;
    logic [15:0] sh;
    logic [3:0]  wt, hv;
    logic        fr_d, head;
    logic [9:0]  cyl;
    always_ff @(posedge aclk) begin
        fr_d <= drv_cmd_frame;
        if (!aresetn) begin
            {k, sh, wt, hv, last_cmd, n_cmds, drv_error, drv_status_valid, cyl, head} <= '0;
            drv_status_word <= 16'hA5A5;
        end else begin
            k <= drv_cmd_frame ? k + 8'h01 : 8'h00;
            // Sample mid-bit; first bit is the lowest
            if (drv_cmd_frame && k[1:0] == 2'h2) sh <= {drv_cmd_data, sh[15:1]};
            if (err_set) drv_error <= 1'b1;
            if (fr_d && !drv_cmd_frame) begin
                last_cmd <= sh;
                n_cmds <= n_cmds + 8'h01;
                if (sh[1:0] == 2'h3) begin
                    if (sh[3]) drv_error <= 1'b0;
                    wt <= {1'b0, delay} + 4'h1;
                end else if (sh[1:0] == 2'h1) begin
                    cyl <= sh[2] ? cyl + sh[15:7] : cyl - sh[15:7];
                    head <= sh[4];
                end
            end
            if (wt != 4'h0) wt <= wt - 4'h1;
            if (hv != 4'h0) hv <= hv - 4'h1;
            if (wt == 4'h1) begin
                drv_status_valid <= 1'b1;
                drv_status_word <= status_in;
                hv <= 4'h8;
            end
            // Released word must not look valid
            if (hv == 4'h1) begin
                drv_status_valid <= 1'b0;
                drv_status_word <= ~drv_status_word;
            end
        end
    end
endmodule

// >>> dv/dcw_props.sv
`timescale 1ns/1ps
module dcw_props
    import dcw_pkg::*;
#(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Drive side
    input wire logic        drv_cmd_frame,
    input wire logic        seek_toward_spindle,
    input wire logic        seek_surface_lower,
    input wire logic [8:0]  seek_cylinders
);
    logic [7:0] fcnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) fcnt <= 8'h00;
        else fcnt <= drv_cmd_frame ? fcnt + 8'h01 : 8'h00;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> s_axi_bvalid) else $error("write response late");
    AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    // Sixteen bits of four cycles each
    AST_FRAME_LEN: assert property ($fell(drv_cmd_frame) && $past(aresetn) |-> fcnt == 8'h40)
        else $error("frame length wrong");
    AST_CYL: assert property ($past(aresetn) && $changed(seek_cylinders)
        |-> $rose(drv_cmd_frame)) else $error("cylinders changed without a seek");
    AST_DIR: assert property ($past(aresetn) && $changed(seek_toward_spindle)
        |-> $rose(drv_cmd_frame)) else $error("direction changed without a seek");
    AST_SURF: assert property ($past(aresetn) && $changed(seek_surface_lower)
        |-> $rose(drv_cmd_frame)) else $error("surface changed without a seek");
    COV_FRAME: cover property ($rose(drv_cmd_frame));
    COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == DCW_RESP_SLVERR);
    COV_STALL: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind dcw_top dcw_props #(.WORD_W(WORD_W)) u_dcw_props (.*);

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
    import dcw_pkg::*;
    logic        aclk, aresetn, err_set, drv_cmd_data, drv_cmd_frame, drv_status_valid, drv_error;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, v, c;
    logic [1:0]  s_axi_bresp, s_axi_rresp, wq[$];
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        seek_toward_spindle, seek_surface_lower;
    logic [15:0] drv_status_word, status_in, last_cmd, bad[3];
    logic [8:0]  seek_cylinders;
    logic [2:0]  delay;
    logic [7:0]  n_cmds;
    logic [65:0] rq[$], re;
    int          num_errors, n_tests, seed, i;
    dcw_top u_dcw_top (.*);
    dcw_drive_model u_dcw_drive_model (.*);
    always #2.5 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t %s got %h want %h", $time, m, s, e);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic hs(input int t);
        if (t >= 50) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int t;
        logic ah, wh, bh;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        wq.push_back(er);
        t = 0;
        do begin
            @(negedge aclk);
            t++;
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            bh = s_axi_bvalid;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end while (!bh && t < 50);
        hs(t);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        int t;
        logic ah, rh;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        rq.push_back({er, m, e});
        t = 0;
        do begin
            @(negedge aclk);
            t++;
            ah = s_axi_arvalid & s_axi_arready;
            rh = s_axi_rvalid;
            v = s_axi_rdata;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
        end while (!rh && t < 50);
        hs(t);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic go(input logic [15:0] cmd);
        int t;
        wr(DCW_OFF_CMD, {16'h0000, cmd}, DCW_RESP_OKAY);
        wr(DCW_OFF_CTRL, 32'h00000001, DCW_RESP_OKAY);
        repeat (4) @(posedge aclk);
        t = 0;
        do begin
            rd(DCW_OFF_STAT, 32'h00000000, 32'h00000000, DCW_RESP_OKAY);
            t++;
        end while (v[0] !== 1'b0 && t < 50);
        hs(t);
    endtask
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk(32'(s_axi_bresp), 32'(wq.pop_front()), "bresp");
        if (s_axi_rvalid && s_axi_rready) begin
            re = rq.pop_front();
            chk(32'(s_axi_rresp), 32'(re[65:64]), "rresp");
            chk(s_axi_rdata & re[63:32], re[31:0], "rdata");
        end
    end
    initial begin
        {aclk, aresetn, err_set, status_in, delay, num_errors, n_tests} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        seed = 32'h2ed97097;
        bad = '{16'h0021, 16'h0013, 16'h0007};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(DCW_OFF_CMD, 32'hFFFFFFFF, {16'h0000, DCW_CMD_RESET}, DCW_RESP_OKAY);
        rd(DCW_OFF_MPR, 32'hFFFFFFFF, {16'h0000, DCW_MPR_RESET}, DCW_RESP_OKAY);
        c = $random(seed);
        wr(DCW_OFF_CMD, c, DCW_RESP_OKAY);
        rd(DCW_OFF_CMD, 32'hFFFFFFFF, {16'h0000, c[15:0]}, DCW_RESP_OKAY);
        wr(4'h2, c, DCW_RESP_SLVERR);
        rd(4'h2, 32'hFFFFFFFF, 32'h00000000, DCW_RESP_SLVERR);
        for (i = 0; i < 4; i++) begin
            c = $random(seed);
            c[6:0] = {2'b00, i[0], 1'b0, i[1], 2'b01};
            go(c[15:0]);
            chk(32'(last_cmd), {16'h0000, c[15:0]}, "sent word");
            chk(32'(seek_toward_spindle), 32'(c[2]), "direction");
            chk(32'(seek_surface_lower), 32'(c[4]), "surface");
            chk(32'(seek_cylinders), 32'(c[15:7]), "cylinders");
            rd(DCW_OFF_STAT, 32'h00000004, 32'h00000004, DCW_RESP_OKAY);
        end
        for (i = 0; i < 2; i++) begin
            err_set <= 1'b1;
            status_in <= 16'($random(seed));
            delay <= 3'($random(seed));
            @(posedge aclk);
            err_set <= 1'b0;
            @(posedge aclk);
            rd(DCW_OFF_STAT, 32'h00000002, 32'h00000002, DCW_RESP_OKAY);
            go({12'h000, i[0], 3'b011});
            chk(32'(last_cmd), {28'h0000000, i[0], 3'b011}, "sent word");
            chk(32'(drv_error), 32'(!i[0]), "drive error");
            rd(DCW_OFF_MPR, 32'hFFFFFFFF, {16'h0000, status_in}, DCW_RESP_OKAY);
            rd(DCW_OFF_STAT, 32'h0000000A, {28'h0, 2'b10, !i[0], 1'b0}, DCW_RESP_OKAY);
        end
        for (i = 0; i < 3; i++) begin
            c = {24'h000000, n_cmds};
            go(bad[i]);
            chk(32'(n_cmds), c, "nothing sent");
            rd(DCW_OFF_STAT, 32'h00000010, 32'h00000010, DCW_RESP_OKAY);
        end
        print_verdict();
    end
endmodule

// >>> rtl/dcw_pkg.sv
package dcw_pkg;

    // Register byte addresses
    localparam logic [3:0]  DCW_OFF_CMD      = 4'h0;
    localparam logic [3:0]  DCW_OFF_MPR      = 4'h4;
    localparam logic [3:0]  DCW_OFF_CTRL     = 4'h8;
    localparam logic [3:0]  DCW_OFF_STAT     = 4'hC;

    localparam logic [15:0] DCW_CMD_RESET    = 16'h0000;
    localparam logic [15:0] DCW_MPR_RESET    = 16'h0000;

    // Command word field positions
    localparam int DCW_BIT_MARKER   = 0;
    localparam int DCW_BIT_STATUS   = 1;
    localparam int DCW_BIT_DIR      = 2;
    localparam int DCW_BIT_RST      = 3;
    localparam int DCW_BIT_SURFACE  = 4;
    localparam int DCW_DIFF_LSB     = 7;
    localparam int DCW_DIFF_W       = 9;

    // Control register bits
    localparam int DCW_CTRL_GO      = 0;
    // Status register bits
    localparam int DCW_STAT_BUSY    = 0;
    localparam int DCW_STAT_FAULT   = 1;
    localparam int DCW_STAT_SEEK    = 2;
    localparam int DCW_STAT_GSTAT   = 3;
    localparam int DCW_STAT_BADFMT  = 4;

    // Serialiser: shift enable every DCW_BIT_DIV cycles
    localparam int DCW_BIT_DIV      = 4;

    localparam logic [1:0] DCW_RESP_OKAY   = 2'b00;
    localparam logic [1:0] DCW_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        DCW_FN_NONE,
        DCW_FN_SEEK,
        DCW_FN_GSTAT,
        DCW_FN_BAD
    } dcw_fn_t;

    // Decoded view of the command word
    typedef struct packed {
        logic [8:0] diff;
        logic       surface;
        logic       dir;
        logic       rst;
        logic       status_req;
        logic       marker;
    } dcw_fields_t;

endpackage

// >>> rtl/dcw_shifter.sv
`timescale 1ns/1ps
module dcw_shifter
    import dcw_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Parallel side
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] word_in,
    output logic                  busy,
    // Bit timing
    input  wire logic             bit_en,
    // Serial side
    output logic                  ser_out,
    output logic                  ser_frame
);

    logic [WIDTH-1:0]         shreg;
    logic [$clog2(WIDTH+1)-1:0] left;

    assign busy      = (left != '0);
    assign ser_frame = busy;

    // LSB first; bit 0 shows at load so the last bit still stands inside the frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg   <= '0;
            left    <= '0;
            ser_out <= 1'b0;
        end else if (load && !busy) begin
            shreg   <= word_in;
            left    <= ($clog2(WIDTH+1))'(WIDTH);
            ser_out <= word_in[0];
        end else if (busy && bit_en) begin
            ser_out <= shreg[1];
            shreg   <= shreg >> 1;
            left    <= left - 1'b1;
        end
    end

endmodule

// >>> rtl/dcw_top.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Direction one moves heads toward spindle
// - Direction zero moves heads away
// - Bits 7-15 give cylinders to travel
// - Bit 4 one lower, zero upper head
// - Bit 1 with marker requests status
// - Returned status readable at readback address
// - Reset bit: drive clears errors first
// - Readback address returns buffer output word
// - Status with reset clears fault flag
// - Command word cleared, fully read/write
module dcw_top
    import dcw_pkg::*;
#(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Drive bus
    output logic                   drv_cmd_data,
    output logic                   drv_cmd_frame,
    input  wire logic              drv_status_valid,
    input  wire logic [WORD_W-1:0] drv_status_word,
    input  wire logic              drv_error,
    // Decoded seek command for the drive side
    output logic                   seek_toward_spindle,
    output logic                   seek_surface_lower,
    output logic [8:0]             seek_cylinders
);

    logic [WORD_W-1:0] disk_command_word;
    logic [WORD_W-1:0] multipurpose_readback;
    logic              drive_fault_flag;
    logic              wait_status;
    logic              seek_done;
    logic              gstat_done;
    logic              bad_format;
    logic [1:0]        div_cnt;
    logic              aw_held;
    logic              w_held;
    logic [3:0]        aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;

    dcw_fields_t       f;
    dcw_fn_t           fn;
    logic              sh_busy;
    logic              bit_en;
    logic              issue;
    logic              do_write;
    logic              wr_cmd;
    logic              wr_ctrl;
    logic              wr_ok;
    logic [WORD_W-1:0] next_cmd;
    logic [31:0]       rd_word;
    logic              rd_ok;
    logic              busy;

    assign f = dcw_fields_t'({disk_command_word[15:7], disk_command_word[DCW_BIT_SURFACE],
                              disk_command_word[DCW_BIT_DIR], disk_command_word[DCW_BIT_RST],
                              disk_command_word[DCW_BIT_STATUS],
                              disk_command_word[DCW_BIT_MARKER]});

    // Function classification from marker and status-request bits
    wire seek_fmt  = f.marker && !f.status_req && !f.rst
                     && disk_command_word[6:5] == 2'b00;
    wire gstat_fmt = f.marker && f.status_req && !f.dir
                     && disk_command_word[15:4] == 12'h000;
    assign fn = !f.marker ? DCW_FN_NONE :
                f.status_req ? (gstat_fmt ? DCW_FN_GSTAT : DCW_FN_BAD) :
                seek_fmt ? DCW_FN_SEEK : DCW_FN_BAD;

    assign busy = sh_busy || wait_status;

    // AXI write path: address and data accepted in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    wire aw_now   = aw_held || (s_axi_awvalid && s_axi_awready);
    wire w_now    = w_held || (s_axi_wvalid && s_axi_wready);
    wire [3:0]  wa = aw_held ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data_q : s_axi_wdata;
    wire [3:0]  ws = w_held ? w_strb_q : s_axi_wstrb;
    assign do_write = aw_now && w_now && !s_axi_bvalid;
    assign wr_cmd   = do_write && wa == DCW_OFF_CMD;
    assign wr_ctrl  = do_write && wa == DCW_OFF_CTRL;
    assign wr_ok    = wa == DCW_OFF_CMD || wa == DCW_OFF_CTRL;
    // Writing while a command is on the wire would corrupt it; held off
    assign issue    = wr_ctrl && ws[0] && wd[DCW_CTRL_GO] && !busy
                      && (fn == DCW_FN_SEEK || fn == DCW_FN_GSTAT);

    assign next_cmd = {ws[1] ? wd[15:8] : disk_command_word[15:8],
                       ws[0] ? wd[7:0]  : disk_command_word[7:0]};

    // AXI read decode
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_ok = s_axi_araddr == DCW_OFF_CMD || s_axi_araddr == DCW_OFF_MPR
                   || s_axi_araddr == DCW_OFF_CTRL || s_axi_araddr == DCW_OFF_STAT;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            DCW_OFF_CMD:  rd_word[WORD_W-1:0] = disk_command_word;
            DCW_OFF_MPR:  rd_word[WORD_W-1:0] = multipurpose_readback;
            DCW_OFF_STAT: rd_word[4:0] = {bad_format, gstat_done, seek_done,
                                          drive_fault_flag, busy};
            default:      rd_word = 32'h0000_0000;
        endcase
    end

    assign bit_en = (div_cnt == 2'(DCW_BIT_DIV - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= DCW_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !do_write) begin
                aw_held   <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !do_write) begin
                w_held   <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? DCW_RESP_OKAY : DCW_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= DCW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? DCW_RESP_OKAY : DCW_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disk_command_word <= DCW_CMD_RESET;
        end else if (wr_cmd && !busy) begin
            disk_command_word <= next_cmd;
        end
    end

    // Function sequencing and status capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt               <= 2'h0;
            wait_status           <= 1'b0;
            multipurpose_readback <= DCW_MPR_RESET;
            seek_done             <= 1'b0;
            gstat_done            <= 1'b0;
            bad_format            <= 1'b0;
            seek_toward_spindle   <= 1'b0;
            seek_surface_lower    <= 1'b0;
            seek_cylinders        <= 9'h000;
        end else begin
            // Restart at issue so every bit lasts a full divider period
            div_cnt <= (bit_en || issue) ? 2'h0 : div_cnt + 2'h1;
            if (wr_ctrl && ws[0] && wd[DCW_CTRL_GO] && fn == DCW_FN_BAD) begin
                bad_format <= 1'b1;
            end else if (issue) begin
                bad_format <= 1'b0;
            end
            if (issue) begin
                seek_done  <= 1'b0;
                gstat_done <= 1'b0;
            end
            if (issue && fn == DCW_FN_SEEK) begin
                seek_toward_spindle <= f.dir;
                seek_surface_lower  <= f.surface;
                seek_cylinders      <= f.diff;
                seek_done           <= 1'b1;
            end
            if (issue && fn == DCW_FN_GSTAT) begin
                wait_status <= 1'b1;
            end else if (wait_status && !sh_busy && drv_status_valid) begin
                // Drive applies its error reset before answering
                wait_status           <= 1'b0;
                multipurpose_readback <= drv_status_word;
                gstat_done            <= 1'b1;
            end
        end
    end

    // Fault follows the drive line; set while drv_error is high, cleared the cycle after the drive drops it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_fault_flag <= 1'b0;
        end else if (drv_error) begin
            drive_fault_flag <= 1'b1;
        end else if (wait_status && !sh_busy && drv_status_valid && f.rst) begin
            drive_fault_flag <= 1'b0;
        end else begin
            drive_fault_flag <= drv_error;
        end
    end

    dcw_shifter #(
        .WIDTH (WORD_W)
    ) u_shifter (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .load      (issue),
        .word_in   (disk_command_word),
        .busy      (sh_busy),
        .bit_en    (bit_en),
        .ser_out   (drv_cmd_data),
        .ser_frame (drv_cmd_frame)
    );

endmodule
